// *** logic/dclc_dac.sv ***
/*
  DAC end: takes 32-bit frames, keeps input and DAC registers for two
  channels, clear code, load override mask and power-down state, and
  reacts to the clear, load and lockout pins.
  Assumes the three pins are asynchronous and are synchronised here, and
  that the link is driven by logic on the same clock.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "dclc_defines.svh"
// Behaviour
// - Command 0101 loads clear code from bits 1:0
// - Override 0: channel follows load pin
// - Override 1: channel updates as if pin low
// - Command 0110 sets override, bit3 B bit0 A
// - Lockout low refuses software power-down
// - Lockout falling edge aborts current frame
// - Software resends aborted frame through the host
// - Lockout asserted clears all power-down bits
// - Lockout release keeps channels powered up
// - Lockout release re-enables power-down immediately
// - Lockout with clear: clear code, power up
// - Clear wins over load and lockout
// - Lockout best tied statically by system
// - Clear selection 00/01/10 codes, 11 no-op; 11 here still powers up, aborts frame
// - Clear edge loads registers, aborts frame
// - Command 0100 power-down, mode bits 9:8
// - Pin low: DAC updates at 32nd edge
module dclc_dac #(
  parameter int DATA_W = 16 // Code width
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pins
  input wire logic async_clear_n_i,
  input wire logic load_outputs_n_i,
  input wire logic shutdown_lockout_n_i,
  // Link
  dclc_link_if.dac link,
  // Channel state
  output logic [DATA_W-1:0] dac_a_o,
  output logic [DATA_W-1:0] dac_b_o,
  output logic [1:0] pd_mode_a_o,
  output logic [1:0] pd_mode_b_o,
  output logic [1:0] clear_code_sel_o,
  output logic [3:0] load_override_mask_o,
  output logic clear_mode_o
);
  import dclc_pkg::*;
  // Two-flop synchronisers for the three asynchronous pins only. The link
  // comes from logic on this same clock, so it is read directly: another
  // synchroniser there would only add latency to every bit.
  logic [2:0] s1_r; // First stage, read by nothing but the second
  logic [2:0] s2_r; // Second stage, the only copy logic may use
  logic sclk_d_r; // Serial clock one cycle ago
  logic clr_d_r; // Synchronised clear one cycle ago
  logic lock_d_r; // Synchronised lockout one cycle ago
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Idle level of every pin, so no false edge follows reset
      s1_r <= 3'h7;
      s2_r <= 3'h7;
    end else begin
      s1_r <= {async_clear_n_i, load_outputs_n_i, shutdown_lockout_n_i};
      s2_r <= s1_r;
    end
  end
  logic sel_n; // Frame select, low inside a frame
  logic sclk; // Serial clock, idle high
  logic sd; // Serial data bit
  logic clr_n; // Clear pin after the synchroniser
  logic ld_n; // Load pin after the synchroniser
  logic lock_n; // Lockout pin after the synchroniser
  assign sel_n = link.frame_sel_n;
  assign sclk = link.sclk;
  assign sd = link.sdata;
  assign {clr_n, ld_n, lock_n} = s2_r;
  // Edge history; reset to idle levels for the same reason as above
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) {sclk_d_r, clr_d_r, lock_d_r} <= 3'h7;
    else {sclk_d_r, clr_d_r, lock_d_r} <= {sclk, clr_n, lock_n};
  end
  logic fall_sclk; // Serial clock falling inside a frame: take a bit
  logic clr_evt; // Clear falling edge
  logic lock_evt; // Lockout falling edge
  assign fall_sclk = sclk_d_r && !sclk && !sel_n;
  assign clr_evt = clr_d_r && !clr_n; // Clear is falling-edge sensitive
  assign lock_evt = lock_d_r && !lock_n; // Only the edge aborts, not the level
  // Clear code lookup
  function automatic logic [DATA_W-1:0] clr_code(input logic [1:0] s);
    logic [15:0] c;
    c = `DCLC_CODE_ZERO;
    case (s)
      2'h1: c = `DCLC_CODE_MID;
      2'h2: c = `DCLC_CODE_FULL;
      default: c = `DCLC_CODE_ZERO;
    endcase
    return c[15 -: DATA_W];
  endfunction
  // Receiver state
  logic [31:0] sh_r; // Shift register
  logic [5:0] bits_r; // Bits taken this frame
  logic abort_r; // Frame killed, wait for select high
  logic frame_done;
  logic [31:0] fr;
  assign fr = {sh_r[30:0], sd};
  assign frame_done = fall_sclk && !abort_r && !clr_evt && !lock_evt &&
                      bits_r == 6'(`DCLC_FRAME_BITS - 1);
  // Shift in MSB first; clear or lockout edge aborts the frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_r <= 32'h0;
      bits_r <= 6'h0;
      abort_r <= 1'b0;
    end else if (sel_n) begin
      bits_r <= 6'h0;
      abort_r <= 1'b0;
    end else if (clr_evt || lock_evt) begin
      abort_r <= 1'b1;
    end else if (fall_sclk && !abort_r) begin
      sh_r <= fr;
      bits_r <= frame_done ? 6'h0 : bits_r + 6'h1;
      abort_r <= frame_done; // Extra clocks after 32 are ignored
    end
  end
  logic [3:0] cmd;
  logic [3:0] adr;
  assign cmd = fr[`DCLC_CMD_HI:`DCLC_CMD_LO];
  assign adr = fr[`DCLC_ADDR_HI:`DCLC_ADDR_LO];
  // Channel registers
  logic [DATA_W-1:0] in_a_r, in_b_r, dac_a_r, dac_b_r;
  logic [1:0] pd_a_r, pd_b_r, csel_r;
  logic [3:0] ovr_r;
  logic clr_mode_r;
  logic upd_a, upd_b, wr_a, wr_b;
  logic [DATA_W-1:0] wdata;
  assign wdata = fr[`DCLC_DATA_HI -: DATA_W];
  // Commands that write the input registers
  function automatic logic is_write(input logic [3:0] c);
    return c == `DCLC_CMD_WRITE_IN || c == `DCLC_CMD_WRITE_UPD;
  endfunction
  // Channel A answers address 0, B address 3, both answer f
  assign wr_a = frame_done && is_write(cmd) && (adr == 4'h0 || adr == 4'hf);
  assign wr_b = frame_done && is_write(cmd) && (adr == 4'h3 || adr == 4'hf);
  // DAC update: pin low or override bit gives update at frame end, pin low always
  assign upd_a = !ld_n || (frame_done && ovr_r[`DCLC_CH_A_BIT]);
  assign upd_b = !ld_n || (frame_done && ovr_r[`DCLC_CH_B_BIT]);
  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      csel_r <= `DCLC_CLR_SEL_RESET;
      ovr_r <= 4'h0;
    end else if (frame_done && cmd == `DCLC_CMD_CLEAR_CODE) begin
      csel_r <= fr[1:0];
    end else if (frame_done && cmd == `DCLC_CMD_LOAD_OVR) begin
      ovr_r <= {fr[`DCLC_CH_B_BIT], 2'h0, fr[`DCLC_CH_A_BIT]};
    end
  end
  // Input and DAC registers; clear has top priority
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_a_r <= '0;
      in_b_r <= '0;
      dac_a_r <= '0;
      dac_b_r <= '0;
      clr_mode_r <= 1'b0;
    end else if (clr_evt && csel_r != DCLC_CLR_NOP) begin
      in_a_r <= clr_code(csel_r);
      in_b_r <= clr_code(csel_r);
      dac_a_r <= clr_code(csel_r);
      dac_b_r <= clr_code(csel_r);
      clr_mode_r <= 1'b1;
    end else begin
      if (frame_done) clr_mode_r <= 1'b0;
      if (wr_a) in_a_r <= wdata;
      if (wr_b) in_b_r <= wdata;
      if (upd_a || (frame_done && cmd == `DCLC_CMD_UPDATE))
        dac_a_r <= wr_a ? wdata : in_a_r;
      else if (wr_a && cmd == `DCLC_CMD_WRITE_UPD) dac_a_r <= wdata;
      if (upd_b || (frame_done && cmd == `DCLC_CMD_UPDATE))
        dac_b_r <= wr_b ? wdata : in_b_r;
      else if (wr_b && cmd == `DCLC_CMD_WRITE_UPD) dac_b_r <= wdata;
    end
  end
  // Power-down state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_a_r <= 2'h0;
      pd_b_r <= 2'h0;
    end else if (clr_evt || !lock_n) begin
      pd_a_r <= 2'h0;
      pd_b_r <= 2'h0;
    end else if (frame_done && cmd == `DCLC_CMD_POWER) begin
      // Only reached with lockout released, so it acts at once
      if (fr[`DCLC_CH_A_BIT]) pd_a_r <= fr[`DCLC_PD_MODE_HI:`DCLC_PD_MODE_LO];
      if (fr[`DCLC_CH_B_BIT]) pd_b_r <= fr[`DCLC_PD_MODE_HI:`DCLC_PD_MODE_LO];
    end
  end
  assign dac_a_o = dac_a_r;
  assign dac_b_o = dac_b_r;
  assign pd_mode_a_o = pd_a_r;
  assign pd_mode_b_o = pd_b_r;
  assign clear_code_sel_o = csel_r;
  assign load_override_mask_o = ovr_r;
  assign clear_mode_o = clr_mode_r;
endmodule // dclc_dac

// *** logic/dclc_defines.svh ***
/*
  Constants of the dual DAC command block: command codes, frame field
  positions, clear codes and serial timing.
  Assumes inclusion by bare name from the package and both ends.
*/
`ifndef DCLC_DEFINES_SVH
`define DCLC_DEFINES_SVH
`define DCLC_FRAME_BITS 32
`define DCLC_CMD_HI 27
`define DCLC_CMD_LO 24
`define DCLC_CMD_WRITE_IN 4'h0
`define DCLC_CMD_UPDATE 4'h1
`define DCLC_CMD_WRITE_UPD 4'h3
`define DCLC_CMD_POWER 4'h4
`define DCLC_CMD_CLEAR_CODE 4'h5
`define DCLC_CMD_LOAD_OVR 4'h6
`define DCLC_ADDR_HI 23
`define DCLC_ADDR_LO 20
`define DCLC_DATA_HI 19
`define DCLC_DATA_LO 4
`define DCLC_PD_MODE_HI 9
`define DCLC_PD_MODE_LO 8
`define DCLC_CH_B_BIT 3
`define DCLC_CH_A_BIT 0
`define DCLC_CODE_ZERO 16'h0000
`define DCLC_CODE_MID 16'h8000
`define DCLC_CODE_FULL 16'hffff
`define DCLC_CLR_SEL_RESET 2'h0
`define DCLC_SCLK_DIV 4
`define DCLC_OFS_FRAME 2'h0
`define DCLC_OFS_CTRL 2'h1
`endif

// *** logic/dclc_host.sv ***
/*
  Host end: sends one 32-bit frame per order over the serial link.
  Assumes a plain register port from software; orders placed while busy
  are dropped, visible through the busy status bit.
*/
`timescale 1ns/1ps
`include "dclc_defines.svh"
module dclc_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Software register port
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Link
  dclc_link_if.host link
);
  import dclc_pkg::*;
  // Register offsets of this end: 0 frame data, 1 go/status
  localparam logic [1:0] OFS_FRAME = `DCLC_OFS_FRAME;
  localparam logic [1:0] OFS_CTRL = `DCLC_OFS_CTRL;
  logic [31:0] frame_r; // Frame to send
  logic [31:0] shift_r; // Bits still to send
  logic [5:0] cnt_r; // Bits left
  logic busy_r; // Frame in flight
  logic [3:0] div_r; // Serial clock divider
  logic sclk_r, sel_n_r, sd_r; // Pin flops
  logic tick; // Half-period enable
  logic start_r;
  logic [31:0] rdata_r;
  assign tick = (div_r == 4'(`DCLC_SCLK_DIV - 1));
  // Divider giving one-cycle enable pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) div_r <= 4'h0;
    else if (tick || !busy_r) div_r <= 4'h0;
    else div_r <= div_r + 4'h1;
  end
  // Software writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_r <= 32'h0;
      start_r <= 1'b0;
    end else begin
      // A second go right behind the first would restart a frame in flight
      start_r <= wr_i && addr_i == OFS_CTRL && wdata_i[0] && !busy_r && !start_r;
      if (wr_i && addr_i == OFS_FRAME) frame_r <= wdata_i;
    end
  end
  // Shift engine: data changes on rising sclk, DAC samples falling
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      sel_n_r <= 1'b1;
      sclk_r <= 1'b1;
      sd_r <= 1'b0;
      cnt_r <= 6'h0;
      shift_r <= 32'h0;
    end else if (start_r) begin
      busy_r <= 1'b1;
      sel_n_r <= 1'b0;
      sd_r <= frame_r[31];
      shift_r <= {frame_r[30:0], 1'b0};
      cnt_r <= 6'(`DCLC_FRAME_BITS);
    end else if (busy_r && tick) begin
      if (cnt_r == 6'h0) begin
        // Whole frame sent; a frame lost to lockout is resent by software
        busy_r <= 1'b0;
        sel_n_r <= 1'b1;
        sclk_r <= 1'b1;
      end else if (sclk_r) sclk_r <= 1'b0;
      else begin
        sclk_r <= 1'b1;
        cnt_r <= cnt_r - 6'h1;
        sd_r <= shift_r[31];
        shift_r <= {shift_r[30:0], 1'b0};
      end
    end
  end
  // Read data one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) rdata_r <= 32'h0;
    else if (rd_i) rdata_r <= (addr_i == OFS_CTRL) ? {31'h0, busy_r} : frame_r;
    else rdata_r <= 32'h0;
  end
  assign rdata_o = rdata_r;
  assign link.frame_sel_n = sel_n_r;
  assign link.sclk = sclk_r;
  assign link.sdata = sd_r;
endmodule // dclc_host

// *** logic/dclc_link_if.sv ***
/*
  Serial link between the host end and the DAC end: frame select,
  serial clock, data line. Assumes both ends share one system clock.
*/
`timescale 1ns/1ps
interface dclc_link_if;
  logic frame_sel_n; // Low while a frame is sent
  logic sclk; // Serial clock, data taken on falling edge
  logic sdata; // Serial data, MSB first
  modport host (output frame_sel_n, output sclk, output sdata);
  modport dac (input frame_sel_n, input sclk, input sdata);
endinterface

// *** logic/dclc_pkg.sv ***
/*
  Types shared by both ends of the dual DAC command block.
  Assumes dclc_defines.svh is on the include path.
*/
`include "dclc_defines.svh"
package dclc_pkg;
  // Clear code selection
  typedef enum logic [1:0] {
    DCLC_CLR_ZERO = 2'h0,
    DCLC_CLR_MID = 2'h1,
    DCLC_CLR_FULL = 2'h2,
    DCLC_CLR_NOP = 2'h3
  } dclc_clr_sel_t;
  // Frame word of one host order
  typedef logic [`DCLC_FRAME_BITS-1:0] dclc_frame_t;
endpackage

// *** tb/dac_clear_load_outputs_n_lockout_ctrl_test.sv ***
/* Bench joining host and DAC ends over the link.
   Assumes the design files are compiled first; 40 MHz clock. */
`timescale 1ns/1ps
`include "dclc_defines.svh"
module dac_clear_load_outputs_n_lockout_ctrl_test;
  import dclc_pkg::*;
  // Clock, reset, register port
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  // Pins idle high
  logic async_clear_n_i = 1'b1;
  logic load_outputs_n_i = 1'b1;
  logic shutdown_lockout_n_i = 1'b1;
  // DAC end state
  logic [15:0] dac_a_o, dac_b_o;
  logic [1:0] pd_mode_a_o, pd_mode_b_o, clear_code_sel_o;
  logic [3:0] load_override_mask_o;
  logic clear_mode_o;
  int num_errors = 0;
  int compares = 0;
  int seed = 26;
  logic [31:0] r, v, pf; // Random word, read value, power-down frame
  logic [15:0] d; // Last code sent
  logic [1:0] m; // Power-down mode
  logic [15:0] e; // Code for a single-channel write
  dclc_link_if link();
  dclc_host u_dclc_host (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .link(link));
  dclc_dac u_dclc_dac (.clk_i, .rst_i, .async_clear_n_i, .load_outputs_n_i,
    .shutdown_lockout_n_i, .link(link), .dac_a_o, .dac_b_o, .pd_mode_a_o,
    .pd_mode_b_o, .clear_code_sel_o, .load_override_mask_o, .clear_mode_o);
  dclc_link_props u_dclc_link_props (.clk_i, .rst_i, .frame_sel_n(link.frame_sel_n),
    .sclk(link.sclk), .async_clear_n_i, .shutdown_lockout_n_i, .dac_a_o,
    .pd_mode_a_o, .pd_mode_b_o, .clear_code_sel_o, .clear_mode_o);
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [31:0] x);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [31:0] x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 x = rdata_o;
  endtask
  // Send a frame; a nonzero ab drops lockout that many cycles after the busy check
  task automatic send(input dclc_frame_t f, input int ab);
    logic [31:0] b;
    wr(2'h0, f);
    wr(2'h1, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(2'h1, b);
    chk("busy", 32'h1, {31'h0, b[0]});
    repeat (ab) @(posedge clk_i);
    if (ab > 0) shutdown_lockout_n_i <= 1'b0;
    // Bounded wait for frame end, then room to execute
    for (int i = 0; i < 400 && !link.frame_sel_n; i++) @(posedge clk_i);
    // A frame that never ends counts as a mismatch
    chk("frame_end", 32'h1, {31'h0, link.frame_sel_n});
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic [31:0] wrf(input logic [15:0] x);
    return {8'h03, 4'hf, x, 4'h0};
  endfunction
  // Code a clear must leave for each selection; 11 keeps what was there
  function automatic logic [31:0] clr_exp(input int s, input logic [15:0] keep);
    case (s)
      0: return {16'h0, `DCLC_CODE_ZERO};
      1: return {16'h0, `DCLC_CODE_MID};
      2: return {16'h0, `DCLC_CODE_FULL};
      default: return {16'h0, keep};
    endcase
  endfunction
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Watchdog: 20000 cycles, room for some 66 frames of about 300 cycles each
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("clear_sel", 32'h0, {30'h0, clear_code_sel_o});
    r = $random(seed);
    wr(2'h0, r);
    rd(2'h0, v);
    chk("frame_word", r, v);
    // Every clear code, with random don't-care bits
    for (int s = 0; s < 4; s++) begin
      d = 16'($random(seed));
      send(wrf(d), 0);
      chk("clear_mode", 32'h0, {31'h0, clear_mode_o});
      r = $random(seed);
      send({r[31:28], 4'h5, r[23:2], 2'(s)}, 0);
      chk("clear_sel", s, {30'h0, clear_code_sel_o});
      async_clear_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      v = clr_exp(s, d);
      chk("dac_a", v, {16'h0, dac_a_o});
      chk("dac_b", v, {16'h0, dac_b_o});
      async_clear_n_i <= 1'b1;
    end
    $display("test clear end");
    // Input register of A alone; pin high, no override: output waits
    e = 16'($random(seed));
    send({8'h00, 4'h0, e, 4'h0}, 0);
    chk("dac_a", d, {16'h0, dac_a_o});
    send({8'h01, 24'h0}, 0);
    chk("dac_a", e, {16'h0, dac_a_o});
    chk("dac_b", d, {16'h0, dac_b_o});
    $display("test update end");
    // Override A only, load pin high
    send({r[31:28], 4'h6, r[23:4], 1'b0, r[2:1], 1'b1}, 0);
    chk("mask", 32'h1, {28'h0, load_override_mask_o});
    v = d;
    d = 16'($random(seed));
    send({8'h00, 4'hf, d, 4'h0}, 0);
    chk("dac_a", d, {16'h0, dac_a_o});
    chk("dac_b", v, {16'h0, dac_b_o});
    load_outputs_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("dac_b", d, {16'h0, dac_b_o});
    load_outputs_n_i <= 1'b1;
    $display("test override end");
    // Power-down, lockout and release
    r = $random(seed);
    m = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
    pf = {8'h04, 14'h0, m, 8'h09};
    send(pf, 0);
    chk("pd_a", m, {30'h0, pd_mode_a_o});
    chk("pd_b", m, {30'h0, pd_mode_b_o});
    shutdown_lockout_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("pd_a", 32'h0, {30'h0, pd_mode_a_o});
    chk("dac_a", d, {16'h0, dac_a_o});
    send(pf, 0);
    chk("pd_b", 32'h0, {30'h0, pd_mode_b_o});
    shutdown_lockout_n_i <= 1'b1;
    send(pf, 0);
    chk("pd_a", m, {30'h0, pd_mode_a_o});
    $display("test lockout end");
    // Lockout in mid-frame, then resend
    send(wrf(~d), 100);
    chk("dac_a", d, {16'h0, dac_a_o});
    chk("pd_b", 32'h0, {30'h0, pd_mode_b_o});
    shutdown_lockout_n_i <= 1'b1;
    send(wrf(~d), 0);
    chk("dac_a", {16'h0, ~d}, {16'h0, dac_a_o});
    $display("test abort end");
    // Clear, lockout and load together
    send(pf, 0);
    send({8'h05, 22'h0, 2'h1}, 0);
    async_clear_n_i <= 1'b0;
    shutdown_lockout_n_i <= 1'b0;
    load_outputs_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("dac_b", 32'h8000, {16'h0, dac_b_o});
    chk("pd_a", 32'h0, {30'h0, pd_mode_a_o});
    $display("test priority end");
    report_and_stop();
  end
endmodule // dac_clear_load_outputs_n_lockout_ctrl_test

// *** tb/dclc_link_props.sv ***
/* Checker of the link and of the DAC end's pin reactions.
   Assumes the bench wires it beside the link; one clock. */
`timescale 1ns/1ps
module dclc_link_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic frame_sel_n,
  input wire logic sclk,
  // Pins
  input wire logic async_clear_n_i,
  input wire logic shutdown_lockout_n_i,
  // DAC end state
  input wire logic [15:0] dac_a_o,
  input wire logic [1:0] pd_mode_a_o,
  input wire logic [1:0] pd_mode_b_o,
  input wire logic [1:0] clear_code_sel_o,
  input wire logic clear_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] nfall_r; // Serial falling edges in this frame
  logic [15:0] exp_code; // Code that a clear must load
  logic pd_off; // Both channels powered up
  // Bit counter restarts at each frame start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) nfall_r <= 6'h0;
    else if ($fell(frame_sel_n)) nfall_r <= 6'h0;
    else if ($fell(sclk)) nfall_r <= nfall_r + 6'h1;
  end
  assign exp_code = clear_code_sel_o[1] ? 16'hffff : {clear_code_sel_o[0], 15'h0};
  assign pd_off = (pd_mode_a_o == 2'h0) && (pd_mode_b_o == 2'h0);
  // Code 11 loads no code and sets no clear mode, so it is left out
  sequence s_clr;
    $fell(async_clear_n_i) && (clear_code_sel_o != 2'h3);
  endsequence
  // Long enough to cover the pin synchroniser
  sequence s_lock;
    !shutdown_lockout_n_i [*6];
  endsequence
  AST_IDLE_SCLK: assert property (frame_sel_n |-> sclk)
    else $error("serial clock low outside a frame");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("serial clock low phase wrong");
  AST_BIT_COUNT: assert property ($rose(frame_sel_n) |-> nfall_r == 6'd32)
    else $error("frame not 32 bits");
  AST_CLEAR_CODE: assert property (s_clr |-> ##[1:6] dac_a_o == exp_code)
    else $error("clear loaded wrong code");
  AST_CLEAR_PWR: assert property (s_clr |-> ##[1:6] pd_off)
    else $error("clear left a channel powered down");
  AST_CLEAR_MODE: assert property (s_clr |-> ##[1:6] clear_mode_o)
    else $error("clear mode not entered");
  // Armed at the 32nd serial falling edge of a frame with both pins idle
  AST_MODE_END: assert property (clear_mode_o && $fell(sclk) && nfall_r == 6'd31
    && async_clear_n_i && shutdown_lockout_n_i |-> ##[1:8] !clear_mode_o)
    else $error("clear mode kept after a frame");
  AST_LOCK_PD: assert property (s_lock |-> pd_off)
    else $error("power-down held under lockout");
  AST_LOCK_REL: assert property ($rose(shutdown_lockout_n_i) |-> pd_off [*4])
    else $error("power-down came back on release");
endmodule // dclc_link_props
